/* pkg/ecr_defines.vh */
`ifndef ECR_DEFINES_VH
`define ECR_DEFINES_VH

// ------------------------------------------------------------
// Register indices
// ------------------------------------------------------------
`define ECR_IDX_VERSION      7'h00
`define ECR_IDX_STRAP        7'h01
`define ECR_IDX_HOST_ONE     7'h02
`define ECR_IDX_HOST_TWO     7'h03
`define ECR_IDX_MEM_ONE      7'h04

// ------------------------------------------------------------
// Port select values
// ------------------------------------------------------------
`define ECR_PORT_INDEX       1'b0
`define ECR_PORT_DATA        1'b1

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define ECR_RST_INDEX        8'h00
`define ECR_RST_HOST_ONE     7'h00
`define ECR_RST_HOST_TWO     8'h02
`define ECR_RST_MEM_ONE      8'h00
`define ECR_RST_STRAP        8'hff

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define ECR_IDX_MSB          6
`define ECR_H1_WIDE_MEM      0
`define ECR_H1_DIG_CLK       1
`define ECR_H1_STD_HTIME     2
`define ECR_H1_ATTR_LO       3
`define ECR_H1_ATTR_HI       4
`define ECR_H1_IO10          5
`define ECR_H1_PAL_ALIAS     6
`define ECR_H1_ATTR_FF       7
`define ECR_H2_PAL_SHADOW    0
`define ECR_H2_WIDE_EN       1
`define ECR_H2_HIGH_BW       3
`define ECR_H2_REFR_PRIO     5
`define ECR_H2_PCI_BURST     6
`define ECR_ST_BUS_LO        0
`define ECR_ST_BUS_HI        2
`define ECR_ST_PINS_ALT      6
`define ECR_ST_CLK_TEST      7

// ------------------------------------------------------------
// Encodings
// ------------------------------------------------------------
`define ECR_BUS_CPU_DIRECT   3'b011
`define ECR_BUS_PCI          3'b110
`define ECR_BUS_VLB          3'b111
`define ECR_ATTR_VGA         2'b00
`define ECR_ATTR_SPLIT       2'b01
`define ECR_ATTR_EGA         2'b10
`define ECR_MEM_AB32         2'b00
`define ECR_MEM_A16          2'b01
`define ECR_MEM_AC32         2'b10

`endif

/* verilog/ecr_strap_latch.v */
`timescale 1ns/10ps
// ------------------------------------------------------------
// Strap capture at reset release
// ------------------------------------------------------------
`include "ecr_defines.vh"

module ecr_strap_latch #(
  parameter WIDTH = 8
) (
  input  wire             clk,
  input  wire             resetn,
  input  wire [WIDTH-1:0] strap_in,
  output wire             pullup_en,
  output reg  [WIDTH-1:0] strap_value
);

  reg captured;

  // Pull-ups on while reset holds the pins
  assign pullup_en = ~resetn | ~captured;

  // Straps sampled on the first clock after release; the async
  // reset only loads a constant, the pin value comes in clocked.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      captured    <= 1'b0;
      strap_value <= `ECR_RST_STRAP;
    end else if (!captured) begin
      captured    <= 1'b1;
      strap_value <= strap_in;
    end
  end

endmodule

/* verilog/ecr_decode.v */
`timescale 1ns/10ps
// ------------------------------------------------------------
// Strap decode
// ------------------------------------------------------------
`include "ecr_defines.vh"

module ecr_decode (
  input  wire [7:0] strap_value,
  output wire       bus_cpu_direct,
  output wire       bus_pci,
  output wire       bus_vlb,
  output wire       bus_reserved,
  output wire       pins_alt,
  output wire       clock_test
);

  wire [2:0] bus_type_strap;

  assign bus_type_strap = strap_value[`ECR_ST_BUS_HI:`ECR_ST_BUS_LO];
  assign bus_cpu_direct = (bus_type_strap == `ECR_BUS_CPU_DIRECT);
  assign bus_pci        = (bus_type_strap == `ECR_BUS_PCI);
  assign bus_vlb        = (bus_type_strap == `ECR_BUS_VLB);
  assign bus_reserved   = ~(bus_cpu_direct | bus_pci | bus_vlb);
  assign pins_alt       = strap_value[`ECR_ST_PINS_ALT];
  // Test mode is the low level of the strap
  assign clock_test     = ~strap_value[`ECR_ST_CLK_TEST];

endmodule

/* verilog/ecr_regs.v */
`timescale 1ns/10ps
`include "ecr_defines.vh"

module ecr_regs #(
  // Arbitrary value; a real part would carry its stepping here
  parameter [7:0] VERSION_CODE = 8'h5a
) (
  input  wire       clk,
  input  wire       resetn,
  // Host port: select chooses index (0) or data (1)
  input  wire       port_sel,
  input  wire       wr_en,
  input  wire       rd_en,
  input  wire [7:0] wr_data,
  output reg  [7:0] rd_data,
  // Strap pins on the memory-A address lines
  input  wire [7:0] dram_a_address_bus,
  output wire       strap_pullup_en,
  // Attribute flip-flop from the attribute unit
  input  wire       attr_ff_data,
  output wire       attr_ff_force_reset,
  // Strap-derived steering
  output wire       bus_cpu_direct,
  output wire       bus_pci,
  output wire       bus_vlb,
  output wire       bus_reserved,
  output wire       upper_addr_en,
  output wire       activity_backlight_en,
  output wire       clock_test_en,
  // Host interface control one
  output wire       wide_mem_access,
  output wire       digital_clk_mode,
  output wire       std_htiming_sel,
  output wire [1:0] attr_mapping,
  output wire       attr_ega_map,
  output wire       io_decode_10bit,
  output wire       palette_alias_en,
  // Host interface control two
  input  wire       palette_write_hit,
  output wire       palette_write_do,
  output wire       palette_write_claim,
  output wire       wide_register_set_en,
  output wire       high_bandwidth_en,
  output wire       refresh_prio_high,
  output wire       pci_burst_en,
  // Memory control one
  output wire [1:0] mem_config,
  output wire       mem_path_32,
  output wire       dram_c_display,
  output wire       ext_fb_allowed
);

  // ------------------------------------------------------------
  // Storage
  // ------------------------------------------------------------
  reg  [7:0] extension_index;
  reg  [6:0] host_if_control_one;
  reg  [7:0] host_if_control_two;
  reg  [7:0] memory_control_one;
  wire [7:0] strap_config_one;
  wire [6:0] sel;

  assign sel = extension_index[`ECR_IDX_MSB:0];

  ecr_strap_latch #(
    .WIDTH       (8)
  ) u_strap (
    .clk         (clk),
    .resetn      (resetn),
    .strap_in    (dram_a_address_bus),
    .pullup_en   (strap_pullup_en),
    .strap_value (strap_config_one)
  );

  ecr_decode u_decode (
    .strap_value    (strap_config_one),
    .bus_cpu_direct (bus_cpu_direct),
    .bus_pci        (bus_pci),
    .bus_vlb        (bus_vlb),
    .bus_reserved   (bus_reserved),
    .pins_alt       (activity_backlight_en),
    .clock_test     (clock_test_en)
  );

  // Strap six low keeps the pins as address bits
  assign upper_addr_en = ~activity_backlight_en;

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      extension_index     <= `ECR_RST_INDEX;
      host_if_control_one <= `ECR_RST_HOST_ONE;
      host_if_control_two <= `ECR_RST_HOST_TWO;
      memory_control_one  <= `ECR_RST_MEM_ONE;
    end else if (wr_en) begin
      if (port_sel == `ECR_PORT_INDEX) begin
        // Top bit is reserved and kept zero
        extension_index <= {1'b0, wr_data[`ECR_IDX_MSB:0]};
      end else if (sel == `ECR_IDX_HOST_ONE) begin
        host_if_control_one <= wr_data[6:0];
      end else if (sel == `ECR_IDX_HOST_TWO) begin
        host_if_control_two <= wr_data;
      end else if (sel == `ECR_IDX_MEM_ONE) begin
        memory_control_one <= wr_data;
      end
    end
  end

  // ------------------------------------------------------------
  // Register reads
  // ------------------------------------------------------------
  // Unmapped indices read zero; the version and strap registers
  // ignore writes since they have no storage behind the port.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_data <= 8'h00;
    end else if (rd_en) begin
      if (port_sel == `ECR_PORT_INDEX) begin
        rd_data <= extension_index;
      end else if (sel == `ECR_IDX_VERSION) begin
        rd_data <= VERSION_CODE;
      end else if (sel == `ECR_IDX_STRAP) begin
        rd_data <= strap_config_one;
      end else if (sel == `ECR_IDX_HOST_ONE) begin
        rd_data <= {attr_ff_data, host_if_control_one};
      end else if (sel == `ECR_IDX_HOST_TWO) begin
        rd_data <= host_if_control_two;
      end else if (sel == `ECR_IDX_MEM_ONE) begin
        rd_data <= memory_control_one;
      end else begin
        rd_data <= 8'h00;
      end
    end
  end

  // ------------------------------------------------------------
  // Host interface control one
  // ------------------------------------------------------------
  assign wide_mem_access  = host_if_control_one[`ECR_H1_WIDE_MEM];
  assign digital_clk_mode = host_if_control_one[`ECR_H1_DIG_CLK];
  assign std_htiming_sel  = host_if_control_one[`ECR_H1_STD_HTIME];
  assign attr_mapping     =
    host_if_control_one[`ECR_H1_ATTR_HI:`ECR_H1_ATTR_LO];
  // Split mapping holds the flip-flop reset
  assign attr_ff_force_reset = (attr_mapping == `ECR_ATTR_SPLIT);
  assign attr_ega_map     = (attr_mapping == `ECR_ATTR_EGA);
  assign io_decode_10bit  = host_if_control_one[`ECR_H1_IO10];
  assign palette_alias_en = host_if_control_one[`ECR_H1_PAL_ALIAS];

  // ------------------------------------------------------------
  // Host interface control two
  // ------------------------------------------------------------
  // The write always lands internally; only the claim is withheld
  assign palette_write_do    = palette_write_hit;
  assign palette_write_claim = palette_write_hit &
    ~host_if_control_two[`ECR_H2_PAL_SHADOW];
  assign wide_register_set_en = host_if_control_two[`ECR_H2_WIDE_EN];
  assign high_bandwidth_en = host_if_control_two[`ECR_H2_HIGH_BW];
  assign refresh_prio_high = host_if_control_two[`ECR_H2_REFR_PRIO];
  assign pci_burst_en      = host_if_control_two[`ECR_H2_PCI_BURST];

  // ------------------------------------------------------------
  // Memory control one
  // ------------------------------------------------------------
  assign mem_config     = memory_control_one[1:0];
  assign mem_path_32    = (mem_config == `ECR_MEM_AB32) |
                          (mem_config == `ECR_MEM_AC32);
  assign dram_c_display = (mem_config == `ECR_MEM_AC32);
  // Reserved 11 also disallows the external buffer
  assign ext_fb_allowed = (mem_config == `ECR_MEM_AB32) |
                          (mem_config == `ECR_MEM_A16);

endmodule

/* bench/ecr_regs_chk.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Port checker
// ----------------------------------------
module ecr_regs_chk (
  input wire       clk,
  input wire       resetn,
  input wire       port_sel,
  input wire       wr_en,
  input wire       rd_en,
  input wire [7:0] rd_data,
  input wire       strap_pullup_en,
  input wire       bus_cpu_direct,
  input wire       bus_pci,
  input wire       bus_vlb,
  input wire       bus_reserved,
  input wire       upper_addr_en,
  input wire       activity_backlight_en,
  input wire       clock_test_en,
  input wire [1:0] attr_mapping,
  input wire       attr_ega_map,
  input wire       attr_ff_force_reset,
  input wire       palette_write_hit,
  input wire       palette_write_do,
  input wire       palette_write_claim,
  input wire [1:0] mem_config,
  input wire       mem_path_32,
  input wire       dram_c_display,
  input wire       ext_fb_allowed
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  pull_rise_a: assert property ($rose(resetn) |-> strap_pullup_en)
    else $error("pull-ups off at reset release");
  pull_drop_a: assert property (strap_pullup_en |=> !strap_pullup_en)
    else $error("pull-ups kept after capture");
  strap_hold_a: assert property (!strap_pullup_en && !$past(strap_pullup_en)
    |-> $stable({bus_pci, bus_vlb, clock_test_en, upper_addr_en}))
    else $error("strap steering moved after capture");
  bus_onehot_a: assert property ($onehot({bus_cpu_direct, bus_pci,
    bus_vlb, bus_reserved})) else $error("bus decode not one-hot");
  pins_alt_a: assert property (upper_addr_en != activity_backlight_en)
    else $error("pin function clash");
  attr_force_a: assert property (attr_ff_force_reset == (attr_mapping == 2'b01))
    else $error("flip-flop hold wrong");
  attr_ega_a: assert property (attr_ega_map == (attr_mapping == 2'b10))
    else $error("ega mapping wrong");
  pal_do_a: assert property (palette_write_do == palette_write_hit)
    else $error("palette write dropped");
  pal_claim_a: assert property (palette_write_claim |-> palette_write_hit)
    else $error("claim without hit");
  mem_path_a: assert property (mem_path_32 == !mem_config[0]
    && ext_fb_allowed == !mem_config[1]
    && dram_c_display == (mem_config == 2'b10)) else $error("mem path wrong");
  rd_hold_a: assert property (!$past(rd_en) |-> $stable(rd_data))
    else $error("read data moved");
  idx_quiet_a: assert property (wr_en && !port_sel
    |=> $stable({mem_config, attr_mapping})) else $error("index write leaked");
  cover property (wr_en && port_sel);
  cover property (rd_en && port_sel);
  cover property (palette_write_hit && !palette_write_claim);
endmodule
bind ecr_regs ecr_regs_chk chk (.*);

/* bench/ecr_host_model.sv */
`timescale 1ns/10ps
// ----------------------------------------
// Host CPU on the index and data ports
// ----------------------------------------
module ecr_host_model (
  input  wire       clk,
  output reg        port_sel,
  output reg        wr_en,
  output reg        rd_en,
  output reg  [7:0] wr_data,
  input  wire [7:0] rd_data
);
  initial begin
    port_sel = 1'b0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    wr_data = 8'h00;
  end
  task automatic wr(input logic s, input logic [7:0] v);
    begin
      @(negedge clk);
      port_sel = s;
      wr_en = 1'b1;
      wr_data = v;
      @(negedge clk);
      wr_en = 1'b0;
      wr_data = ~v; // Idle bus must not look like the last write
    end
  endtask
  task automatic rd(input logic s, output logic [7:0] v);
    begin
      @(negedge clk);
      port_sel = s;
      rd_en = 1'b1;
      @(negedge clk);
      rd_en = 1'b0;
      v = rd_data;
    end
  endtask
endmodule

/* bench/ecr_regs_tb.sv */
`timescale 1ns/10ps
module ecr_regs_tb;
  reg         clk, resetn, attr_ff_data, palette_write_hit;
  reg   [7:0] dram_a_address_bus;
  wire        port_sel, wr_en, rd_en, strap_pullup_en, attr_ff_force_reset;
  wire  [7:0] wr_data, rd_data;
  wire        bus_cpu_direct, bus_pci, bus_vlb, bus_reserved, upper_addr_en;
  wire        activity_backlight_en, clock_test_en, wide_mem_access;
  wire        digital_clk_mode, std_htiming_sel, attr_ega_map;
  wire        io_decode_10bit, palette_alias_en, palette_write_do;
  wire        palette_write_claim, wide_register_set_en, high_bandwidth_en;
  wire        refresh_prio_high, pci_burst_en, mem_path_32, dram_c_display;
  wire        ext_fb_allowed;
  wire  [1:0] attr_mapping, mem_config;
  integer     num_errors, n_tests, cyc, m;
  logic [7:0] d, v;
  ecr_regs uut (.*);
  ecr_host_model host (.*);
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task automatic tally_and_finish;
    begin
      $display("mismatches %0d of %0d checks", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task automatic t_straps(input logic [7:0] s);
    begin
      resetn = 1'b0;
      dram_a_address_bus = s;
      repeat (12) @(negedge clk);
      check(strap_pullup_en, 1'b1);
      check(bus_vlb, 1'b1);
      resetn = 1'b1;
      repeat (2) @(negedge clk);
      dram_a_address_bus = ~s; // Address traffic after capture
      check(strap_pullup_en, 1'b0);
      host.rd(1'b1, d);
      check(d, 8'h5a);
      host.wr(1'b0, 8'h81);
      host.rd(1'b0, d);
      check(d, 8'h01);
      host.wr(1'b1, 8'h00);
      host.rd(1'b1, d);
      check(d, s);
      check({bus_reserved, bus_vlb, bus_pci, bus_cpu_direct},
        {s[2:0] != 3'b011 && s[2:1] != 2'b11, s[2:0] == 3'b111,
         s[2:0] == 3'b110, s[2:0] == 3'b011});
      check({upper_addr_en, activity_backlight_en}, {!s[6], s[6]});
      check(clock_test_en, !s[7]);
      host.wr(1'b0, 8'h03);
      host.rd(1'b1, d);
      check(d, 8'h02);
      host.wr(1'b0, 8'h00);
      host.wr(1'b1, 8'h33);
      host.rd(1'b1, d);
      check(d, 8'h5a);
      host.wr(1'b0, 8'h7f);
      host.wr(1'b1, 8'hff);
      host.rd(1'b1, d);
      check(d, 8'h00);
    end
  endtask
  task automatic t_host_one;
    begin
      host.wr(1'b0, 8'h02);
      for (m = 0; m < 4; m = m + 1) begin
        v = {1'b1, m[0], m[1], m[1:0], m[0], m[1], m[0]};
        attr_ff_data = m[1];
        host.wr(1'b1, v);
        check(wide_mem_access, v[0]);
        check(digital_clk_mode, v[1]);
        check(std_htiming_sel, v[2]);
        check(attr_mapping, v[4:3]);
        check(attr_ff_force_reset, v[4:3] == 2'b01);
        check(attr_ega_map, v[4:3] == 2'b10);
        check(io_decode_10bit, v[5]);
        check(palette_alias_en, v[6]);
        host.rd(1'b1, d);
        check(d, {m[1], v[6:0]});
      end
      host.rd(1'b0, d);
      check(d, 8'h02);
    end
  endtask
  task automatic t_host_two;
    begin
      host.wr(1'b0, 8'h03);
      for (m = 0; m < 2; m = m + 1) begin
        v = m[0] ? 8'h96 : 8'h69;
        host.wr(1'b1, v);
        // Held over a rising edge so the checker sees the hit too
        palette_write_hit = 1'b1;
        @(negedge clk);
        check({palette_write_do, palette_write_claim}, {1'b1, !v[0]});
        palette_write_hit = 1'b0;
        check(wide_register_set_en, v[1]);
        check(high_bandwidth_en, v[3]);
        check(refresh_prio_high, v[5]);
        check(pci_burst_en, v[6]);
        host.rd(1'b1, d);
        check(d, v);
      end
    end
  endtask
  task automatic t_mem;
    begin
      host.wr(1'b0, 8'h04);
      for (m = 0; m < 4; m = m + 1) begin
        host.wr(1'b1, m[7:0]);
        check(mem_config, m[1:0]);
        check({mem_path_32, dram_c_display, ext_fb_allowed},
          {!m[0], m[1:0] == 2'b10, !m[1]});
      end
      host.wr(1'b1, 8'h01);
      host.rd(1'b1, d);
      check(d, 8'h01);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 6000) begin
      num_errors = num_errors + 1;
      tally_and_finish;
    end
  end
  initial begin
    num_errors = 0;
    n_tests = 0;
    cyc = 0;
    resetn = 1'b0;
    attr_ff_data = 1'b0;
    palette_write_hit = 1'b0;
    dram_a_address_bus = 8'hff;
    t_straps(8'hff);
    t_straps(8'h55);
    t_straps(8'h16);
    t_host_one;
    t_host_two;
    t_mem;
    t_straps(8'hd3);
    tally_and_finish;
  end
endmodule
